// [inc/tlb_ctl_pkg.sv]
// Shared constants and carrier types for the translation control block
package tlb_ctl_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int TLB_ENTRIES = 16;
    localparam int INDEX_WIDTH = $clog2(TLB_ENTRIES);
    localparam logic [INDEX_WIDTH-1:0] TOP_ENTRY =
        INDEX_WIDTH'(TLB_ENTRIES - 1);
    localparam logic [INDEX_WIDTH-1:0] BOUNDARY_RESET = 4'h0;

    // ------------------------------------------------------------
    // Register selects on the coprocessor move port
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_PAGE_SIZE = 3'h0;
    localparam logic [2:0] SEL_GRANULARITY = 3'h1;
    localparam logic [2:0] SEL_BOUNDARY = 3'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LPA_BIT = 29;
    localparam int SPE_BIT = 28;
    localparam int MASK_HI = 28;
    localparam int MASK_LO = 13;
    localparam int SMALL_PAGE_SIZE_BITS_HI = 12;
    localparam int SMALL_PAGE_SIZE_BITS_LO = 11;
    localparam int MASK_WIDTH = MASK_HI - MASK_LO + 1;
    localparam logic [1:0] SMALL_PAGE_SIZE_BITS_ONES = 2'h3;
    localparam logic [1:0] SMALL_PAGE_SIZE_BITS_RESET = 2'h0;

    // Page-size encodings kept by this build, one bit per mask pair
    // (bit 0 = 16KB pair 14..13, up to bit 7 = 256MB pair 28..27).
    // The 4KB size needs no mask bits and is always present.
    localparam logic [7:0] SIZES_PRESENT = 8'h0f;
    localparam logic [MASK_WIDTH-1:0] MASK_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [2:0] sel;
        logic [31:0] data;
    } cop_write_type;

    typedef struct packed {
        logic small_page_enable;
        logic [MASK_WIDTH-1:0] page_size_compare_reg;
        logic [1:0] small_page_size_bits;
        logic [INDEX_WIDTH-1:0] fixed_entry_boundary;
    } ctl_state_type;

endpackage : tlb_ctl_pkg

// [core/victim_pointer.sv]
// Random replacement pointer kept at or above the fixed-entry boundary
`timescale 1ns/1ps
module victim_pointer
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_reload,
    input wire logic i_step,
    input wire logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] i_boundary,
    // Pointer
    output logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] o_pointer
);

    typedef struct packed {
        logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] pointer;
    } ptr_state_type;

    ptr_state_type state;
    ptr_state_type next_state;

    // ------------------------------------------------------------
    // Next pointer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (i_reload)
        begin
            next_state.pointer = tlb_ctl_pkg::TOP_ENTRY;
        end
        else if (i_step)
        begin
            // Walk down, wrap to the top at the boundary
            if (state.pointer <= i_boundary)
            begin
                next_state.pointer = tlb_ctl_pkg::TOP_ENTRY;
            end
            else
            begin
                next_state.pointer = state.pointer - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state.pointer <= tlb_ctl_pkg::TOP_ENTRY;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Never below the boundary once stepped
    assign o_pointer = (state.pointer < i_boundary) ?
        tlb_ctl_pkg::TOP_ENTRY : state.pointer;

endmodule : victim_pointer

// [core/reset_sync.sv]
// Two-stage release of the asynchronous reset
`timescale 1ns/1ps
module reset_sync
(
    // Clock and raw reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Released reset
    output logic o_rst_n
);

    typedef struct packed {
        logic first;
        logic second;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    // ------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------
    always_comb
    begin
        next_state.first = 1'b1;
        next_state.second = state.first;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_rst_n = state.second;

endmodule : reset_sync

// [core/tlb_page_ctl.sv]
// Page-size mask, page granularity control and fixed-entry boundary
//
// Contract
// - Small pages off: mask bits 12..11 act as ones
// - 4KB page size always supported
// - Unimplemented size bits read back zero
// - Large address enable bit ignores writes, reads zero
// - Bit 28 is small page enable, resets zero
// - Small pages: frame number holds bits down to 10
// - Small pages: small mask bits writable, appended
// - Small pages: pair extension writable, honoured
// - No capability: enable ignores writes, reads zero
// - Reserved granularity bits read zero, reset zero
// - Random write never overwrites fixed entries unless a boundary write shares its cycle
// - Reset clears fixed-entry boundary
// - Boundary write reloads random pointer to top
// - Boundary field as wide as index
// - Boundary upper bits read zero
// - Small pages off: small bits read zero
`timescale 1ns/1ps
module tlb_page_ctl
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // Capability strap from the third configuration register
    input wire logic I_SMALL_PAGE_CAPABLE,
    // Coprocessor register move port
    input wire tlb_ctl_pkg::cop_write_type I_COP_WRITE,
    input wire logic [2:0] I_COP_READ_SEL,
    output logic [31:0] O_COP_READ_DATA,
    // TLB write operations
    input wire logic I_TLB_WRITE_RANDOM_OP,
    input wire logic I_TLB_WRITE_INDEXED_OP,
    input wire logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] I_INDEX,
    output logic O_TLB_WRITE_EN,
    output logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] O_TLB_WRITE_INDEX,
    // Controls to the translation datapath
    output logic O_SMALL_PAGES_ON,
    output logic [17:0] O_ENTRY_COMPARE_MASK,
    output logic [1:0] O_FRAME_SHIFT,
    output logic O_PAIR_EXTENSION_WRITABLE
);

    // ------------------------------------------------------------
    // Internal reset and state
    // ------------------------------------------------------------
    logic rst_n;
    logic small_pages_on;
    logic boundary_write;
    logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] victim;
    logic [tlb_ctl_pkg::MASK_WIDTH-1:0] size_keep;
    logic [31:0] read_mux;
    tlb_ctl_pkg::ctl_state_type state;
    tlb_ctl_pkg::ctl_state_type next_state;

    // Frame-number shift for the small-page layout
    localparam logic [1:0] FRAME_SHIFT_SMALL = 2'h2;
    localparam logic [1:0] FRAME_SHIFT_NONE = 2'h0;

    typedef struct packed {
        logic wr_en;
        logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] wr_index;
        logic [31:0] read_data;
    } out_state_type;

    out_state_type out_q;
    out_state_type next_out;

    reset_sync u_reset_sync
    (
        .i_clk(I_CLK),
        .i_rst_n(I_RESET_N),
        .o_rst_n(rst_n)
    );

    // ------------------------------------------------------------
    // Supported size mask
    // ------------------------------------------------------------
    always_comb
    begin
        size_keep = '0;
        for (int p = 0; p < tlb_ctl_pkg::MASK_WIDTH / 2; p++)
        begin
            // Absent encodings drop their bit pair
            size_keep[2*p] = tlb_ctl_pkg::SIZES_PRESENT[p];
            size_keep[2*p+1] = tlb_ctl_pkg::SIZES_PRESENT[p];
        end
    end

    // Small pages need both the capability and the enable
    assign small_pages_on = I_SMALL_PAGE_CAPABLE &&
        state.small_page_enable;

    assign boundary_write = I_COP_WRITE.wr &&
        (I_COP_WRITE.sel == tlb_ctl_pkg::SEL_BOUNDARY);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (I_COP_WRITE.wr)
        begin
            case (I_COP_WRITE.sel)
                tlb_ctl_pkg::SEL_PAGE_SIZE:
                begin
                    // Keep only implemented size pairs
                    next_state.page_size_compare_reg =
                        I_COP_WRITE.data[tlb_ctl_pkg::MASK_HI:
                        tlb_ctl_pkg::MASK_LO] & size_keep;
                    if (small_pages_on)
                    begin
                        next_state.small_page_size_bits =
                            I_COP_WRITE.data[tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_HI:
                            tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_LO];
                    end
                end
                tlb_ctl_pkg::SEL_GRANULARITY:
                begin
                    // Large address bit and reserved bits dropped
                    next_state.small_page_enable = I_SMALL_PAGE_CAPABLE &&
                        I_COP_WRITE.data[tlb_ctl_pkg::SPE_BIT];
                end
                tlb_ctl_pkg::SEL_BOUNDARY:
                begin
                    next_state.fixed_entry_boundary =
                        I_COP_WRITE.data[tlb_ctl_pkg::INDEX_WIDTH-1:0];
                end
                default:
                begin
                    next_state = state;
                end
            endcase
        end
        // Disabled small pages: stored bits forced clear
        if (!(I_SMALL_PAGE_CAPABLE && next_state.small_page_enable))
        begin
            next_state.small_page_size_bits =
                tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_RESET;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        read_mux = '0;
        case (I_COP_READ_SEL)
            tlb_ctl_pkg::SEL_PAGE_SIZE:
            begin
                read_mux[tlb_ctl_pkg::MASK_HI:tlb_ctl_pkg::MASK_LO] =
                    state.page_size_compare_reg;
                read_mux[tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_HI:tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_LO] =
                    small_pages_on ? state.small_page_size_bits :
                    tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_RESET;
            end
            tlb_ctl_pkg::SEL_GRANULARITY:
            begin
                // Extension and reserved fields stay zero
                read_mux[tlb_ctl_pkg::LPA_BIT] = 1'b0;
                read_mux[tlb_ctl_pkg::SPE_BIT] = small_pages_on;
            end
            tlb_ctl_pkg::SEL_BOUNDARY:
            begin
                // Upper bits stay zero
                read_mux[tlb_ctl_pkg::INDEX_WIDTH-1:0] =
                    state.fixed_entry_boundary;
            end
            default:
            begin
                read_mux = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Random pointer
    // ------------------------------------------------------------
    victim_pointer u_victim_pointer
    (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_reload(boundary_write),
        .i_step(1'b1),
        .i_boundary(state.fixed_entry_boundary),
        .o_pointer(victim)
    );

    // ------------------------------------------------------------
    // TLB write target and registered read data
    // ------------------------------------------------------------
    always_comb
    begin
        next_out.read_data = read_mux;
        next_out.wr_en = I_TLB_WRITE_RANDOM_OP || I_TLB_WRITE_INDEXED_OP;
        if (I_TLB_WRITE_INDEXED_OP)
        begin
            // Indexed writes may touch fixed entries
            next_out.wr_index = I_INDEX;
        end
        else if (I_TLB_WRITE_RANDOM_OP)
        begin
            next_out.wr_index = victim;
        end
        else
        begin
            next_out.wr_index = out_q.wr_index;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state.small_page_enable <= 1'b0;
            state.page_size_compare_reg <= tlb_ctl_pkg::MASK_RESET;
            state.small_page_size_bits <= tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_RESET;
            state.fixed_entry_boundary <=
                tlb_ctl_pkg::BOUNDARY_RESET;
            out_q <= '0;
        end
        else
        begin
            state <= next_state;
            out_q <= next_out;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_COP_READ_DATA = out_q.read_data;
    assign O_TLB_WRITE_EN = out_q.wr_en;
    assign O_TLB_WRITE_INDEX = out_q.wr_index;
    assign O_SMALL_PAGES_ON = small_pages_on;
    // Small pages off: 4KB and larger compare through the main mask alone
    assign O_ENTRY_COMPARE_MASK = {state.page_size_compare_reg,
        small_pages_on ? state.small_page_size_bits :
        tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_ONES};
    assign O_FRAME_SHIFT = small_pages_on ? FRAME_SHIFT_SMALL :
        FRAME_SHIFT_NONE;
    assign O_PAIR_EXTENSION_WRITABLE = small_pages_on;

endmodule : tlb_page_ctl

// [tb/tlb_page_ctl_chk.sv]
// Port assertions for the translation control block
`timescale 1ns/1ps
module tlb_page_ctl_chk
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // Watched inputs
    input wire logic I_SMALL_PAGE_CAPABLE,
    input wire tlb_ctl_pkg::cop_write_type I_COP_WRITE,
    input wire logic [2:0] I_COP_READ_SEL,
    input wire logic I_TLB_WRITE_RANDOM_OP,
    input wire logic I_TLB_WRITE_INDEXED_OP,
    input wire logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] I_INDEX,
    // Watched outputs
    input wire logic [31:0] O_COP_READ_DATA,
    input wire logic O_TLB_WRITE_EN,
    input wire logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] O_TLB_WRITE_INDEX,
    input wire logic O_SMALL_PAGES_ON,
    input wire logic [17:0] O_ENTRY_COMPARE_MASK,
    input wire logic [1:0] O_FRAME_SHIFT,
    input wire logic O_PAIR_EXTENSION_WRITABLE
);
    logic [tlb_ctl_pkg::INDEX_WIDTH-1:0] bnd;
    logic bwr;
    logic rnd;

    // Boundary write and lone random request
    assign bwr = I_COP_WRITE.wr &&
        I_COP_WRITE.sel == tlb_ctl_pkg::SEL_BOUNDARY;
    assign rnd = I_TLB_WRITE_RANDOM_OP && !I_TLB_WRITE_INDEXED_OP;

    // Boundary as last written by software
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            bnd <= tlb_ctl_pkg::BOUNDARY_RESET;
        else if (bwr)
            bnd <= I_COP_WRITE.data[tlb_ctl_pkg::INDEX_WIDTH-1:0];
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_random_above_fixed:
        assert property (rnd && !bwr |=> O_TLB_WRITE_EN
            && O_TLB_WRITE_INDEX >= bnd) else $error("random write in fixed");
    a_indexed_target:
        assert property (I_TLB_WRITE_INDEXED_OP |=> O_TLB_WRITE_EN
            && O_TLB_WRITE_INDEX == $past(I_INDEX)) else $error("bad index");
    a_no_op_idle:
        assert property (!I_TLB_WRITE_RANDOM_OP && !I_TLB_WRITE_INDEXED_OP
            |=> !O_TLB_WRITE_EN) else $error("spurious tlb write");
    a_reload_top:
        assert property (bwr ##1 rnd |=> O_TLB_WRITE_INDEX
            == tlb_ctl_pkg::TOP_ENTRY) else $error("pointer not reloaded");
    a_enable_gated:
        assert property (!I_SMALL_PAGE_CAPABLE |-> !O_SMALL_PAGES_ON)
        else $error("small pages on without capability");
    a_small_off_ones:
        assert property (!O_SMALL_PAGES_ON |-> O_ENTRY_COMPARE_MASK[1:0]
            == tlb_ctl_pkg::SMALL_PAGE_SIZE_BITS_ONES) else $error("low mask not ones");
    a_frame_shift:
        assert property (O_FRAME_SHIFT == (O_SMALL_PAGES_ON ? 2'h2 : 2'h0)
            && O_PAIR_EXTENSION_WRITABLE == O_SMALL_PAGES_ON)
        else $error("shift or extension wrong");
    a_gran_reserved:
        assert property ($past(I_COP_READ_SEL) == tlb_ctl_pkg::SEL_GRANULARITY
            |-> (O_COP_READ_DATA & 32'hefffffff) == 32'h0)
        else $error("granularity reserved bits set");
    a_mask_absent:
        assert property ($past(I_COP_READ_SEL) == tlb_ctl_pkg::SEL_PAGE_SIZE
            |-> (O_COP_READ_DATA & 32'hffe007ff) == 32'h0)
        else $error("absent size bits set");
    a_small_bits_zero:
        assert property ($past(I_COP_READ_SEL) == tlb_ctl_pkg::SEL_PAGE_SIZE
            && !$past(O_SMALL_PAGES_ON) |-> O_COP_READ_DATA[12:11] == 2'h0)
        else $error("small bits read while off");
    a_boundary_read:
        assert property ($past(I_COP_READ_SEL) == tlb_ctl_pkg::SEL_BOUNDARY
            |-> O_COP_READ_DATA == {28'h0, $past(bnd)})
        else $error("boundary read wrong");
    a_enable_follows:
        assert property (I_COP_WRITE.wr && I_COP_WRITE.sel ==
            tlb_ctl_pkg::SEL_GRANULARITY && I_SMALL_PAGE_CAPABLE
            ##1 I_SMALL_PAGE_CAPABLE |-> O_SMALL_PAGES_ON
            == $past(I_COP_WRITE.data[tlb_ctl_pkg::SPE_BIT]))
        else $error("enable not taken from write");

    c_random: cover property (rnd);
    c_reload: cover property (bwr ##1 rnd);
    c_small_on: cover property (O_SMALL_PAGES_ON);
endmodule : tlb_page_ctl_chk

bind tlb_page_ctl tlb_page_ctl_chk u_tlb_page_ctl_chk (.I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N), .I_SMALL_PAGE_CAPABLE(I_SMALL_PAGE_CAPABLE),
    .I_COP_WRITE(I_COP_WRITE), .I_COP_READ_SEL(I_COP_READ_SEL),
    .I_TLB_WRITE_RANDOM_OP(I_TLB_WRITE_RANDOM_OP),
    .I_TLB_WRITE_INDEXED_OP(I_TLB_WRITE_INDEXED_OP), .I_INDEX(I_INDEX),
    .O_COP_READ_DATA(O_COP_READ_DATA), .O_TLB_WRITE_EN(O_TLB_WRITE_EN),
    .O_TLB_WRITE_INDEX(O_TLB_WRITE_INDEX), .O_SMALL_PAGES_ON(O_SMALL_PAGES_ON),
    .O_ENTRY_COMPARE_MASK(O_ENTRY_COMPARE_MASK), .O_FRAME_SHIFT(O_FRAME_SHIFT),
    .O_PAIR_EXTENSION_WRITABLE(O_PAIR_EXTENSION_WRITABLE));

// [tb/testbench.sv]
// Self-checking bench for the translation control block
`timescale 1ns/1ps
`define CHK(g, e) \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
        err_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end
module testbench;
    localparam int IW = tlb_ctl_pkg::INDEX_WIDTH;
    localparam logic [2:0] sel_mask = tlb_ctl_pkg::SEL_PAGE_SIZE;
    localparam logic [2:0] sel_gran = tlb_ctl_pkg::SEL_GRANULARITY;
    localparam logic [2:0] sel_bnd = tlb_ctl_pkg::SEL_BOUNDARY;
    int err_count = 0;
    int comparisons = 0;
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic I_SMALL_PAGE_CAPABLE = 1'b0;
    tlb_ctl_pkg::cop_write_type I_COP_WRITE = '0;
    logic [2:0] I_COP_READ_SEL = 3'h0;
    logic I_TLB_WRITE_RANDOM_OP = 1'b0;
    logic I_TLB_WRITE_INDEXED_OP = 1'b0;
    logic [IW-1:0] I_INDEX = '0;
    logic [31:0] O_COP_READ_DATA;
    logic O_TLB_WRITE_EN;
    logic [IW-1:0] O_TLB_WRITE_INDEX;
    logic O_SMALL_PAGES_ON;
    logic [17:0] O_ENTRY_COMPARE_MASK;
    logic [1:0] O_FRAME_SHIFT;
    logic O_PAIR_EXTENSION_WRITABLE;
    logic [IW-1:0] got;

    // 50 MHz clock
    always #10 I_CLK = ~I_CLK;

    // Device under test
    tlb_page_ctl u_tlb_page_ctl (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_SMALL_PAGE_CAPABLE(I_SMALL_PAGE_CAPABLE), .I_COP_WRITE(I_COP_WRITE),
        .I_COP_READ_SEL(I_COP_READ_SEL), .O_COP_READ_DATA(O_COP_READ_DATA),
        .I_TLB_WRITE_RANDOM_OP(I_TLB_WRITE_RANDOM_OP),
        .I_TLB_WRITE_INDEXED_OP(I_TLB_WRITE_INDEXED_OP), .I_INDEX(I_INDEX),
        .O_TLB_WRITE_EN(O_TLB_WRITE_EN), .O_TLB_WRITE_INDEX(O_TLB_WRITE_INDEX),
        .O_SMALL_PAGES_ON(O_SMALL_PAGES_ON),
        .O_ENTRY_COMPARE_MASK(O_ENTRY_COMPARE_MASK),
        .O_FRAME_SHIFT(O_FRAME_SHIFT),
        .O_PAIR_EXTENSION_WRITABLE(O_PAIR_EXTENSION_WRITABLE));

    // --------
    // Bus tasks
    // --------
    task automatic cop_wr(input logic [2:0] sel, input logic [31:0] data);
        @(posedge I_CLK);
        I_COP_WRITE <= '{1'b1, sel, data};
        @(posedge I_CLK);
        I_COP_WRITE.wr <= 1'b0;
    endtask : cop_wr

    task automatic rd_chk(input logic [2:0] sel, input logic [31:0] exp);
        @(posedge I_CLK);
        I_COP_READ_SEL <= sel;
        @(posedge I_CLK);
        #1;
        `CHK(O_COP_READ_DATA, exp)
    endtask : rd_chk

    task automatic op(input logic r, input logic x, input logic [IW-1:0] ix);
        @(posedge I_CLK);
        I_TLB_WRITE_RANDOM_OP <= r;
        I_TLB_WRITE_INDEXED_OP <= x;
        I_INDEX <= ix;
        @(posedge I_CLK);
        I_TLB_WRITE_RANDOM_OP <= 1'b0;
        I_TLB_WRITE_INDEXED_OP <= 1'b0;
        #1;
        `CHK(O_TLB_WRITE_EN, 1'b1)
        got = O_TLB_WRITE_INDEX;
    endtask : op

    task automatic do_reset(input int n);
        I_RESET_N <= 1'b0;
        repeat (n) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        repeat (3) @(posedge I_CLK);
    endtask : do_reset

    // --------
    // Scenarios
    // --------
    task automatic t_reset_values();
        rd_chk(sel_gran, 32'h0);
        rd_chk(sel_bnd, 32'h0);
        `CHK(O_ENTRY_COMPARE_MASK, 18'h00003)
        $display("reset values done");
    endtask : t_reset_values

    task automatic t_probe_sizes();
        cop_wr(sel_mask, 32'hffffffff);
        rd_chk(sel_mask, 32'h001fe000);
        `CHK(O_ENTRY_COMPARE_MASK, 18'h003ff)
        $display("size probe done");
    endtask : t_probe_sizes

    task automatic t_no_capability();
        cop_wr(sel_gran, 32'h30000000);
        rd_chk(sel_gran, 32'h0);
        `CHK(O_SMALL_PAGES_ON, 1'b0)
        $display("no capability done");
    endtask : t_no_capability

    task automatic t_small_pages();
        I_SMALL_PAGE_CAPABLE <= 1'b1;
        cop_wr(sel_mask, 32'h00001800);
        cop_wr(sel_gran, 32'h30000000);
        rd_chk(sel_gran, 32'h10000000);
        `CHK(O_FRAME_SHIFT, 2'h2)
        `CHK(O_PAIR_EXTENSION_WRITABLE, 1'b1)
        cop_wr(sel_mask, 32'h00007800);
        rd_chk(sel_mask, 32'h00007800);
        `CHK(O_ENTRY_COMPARE_MASK, 18'h0000f)
        cop_wr(sel_mask, 32'h00000000);
        rd_chk(sel_mask, 32'h00000000);
        `CHK(O_ENTRY_COMPARE_MASK, 18'h00000)
        cop_wr(sel_mask, 32'h00001800);
        rd_chk(sel_mask, 32'h00001800);
        cop_wr(sel_gran, 32'h0);
        rd_chk(sel_mask, 32'h0);
        `CHK(O_ENTRY_COMPARE_MASK, 18'h00003)
        `CHK(O_FRAME_SHIFT, 2'h0)
        $display("small pages done");
    endtask : t_small_pages

    task automatic t_boundary();
        @(posedge I_CLK);
        I_COP_WRITE <= '{1'b1, sel_bnd, 32'h00000003};
        @(posedge I_CLK);
        I_COP_WRITE.wr <= 1'b0;
        I_TLB_WRITE_RANDOM_OP <= 1'b1;
        @(posedge I_CLK);
        I_TLB_WRITE_RANDOM_OP <= 1'b0;
        #1;
        `CHK(O_TLB_WRITE_INDEX, tlb_ctl_pkg::TOP_ENTRY)
        rd_chk(sel_bnd, 32'h3);
        // Random writes over a full pointer lap
        for (int i = 0; i < 20; i++)
        begin
            op(1'b1, 1'b0, 4'h0);
            `CHK(got >= 4'h3, 1'b1)
        end
        op(1'b0, 1'b1, 4'h1);
        `CHK(got, 4'h1)
        op(1'b1, 1'b1, 4'h2);
        `CHK(got, 4'h2)
        cop_wr(sel_bnd, 32'h0000000f);
        op(1'b1, 1'b0, 4'h0);
        `CHK(got, 4'hf)
        do_reset(2);
        rd_chk(sel_bnd, 32'h0);
        $display("boundary done");
    endtask : t_boundary

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // Main sequence
    initial
    begin
        repeat (12) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        repeat (3) @(posedge I_CLK);
        t_reset_values();
        t_probe_sizes();
        t_no_capability();
        t_small_pages();
        t_boundary();
        summarize();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge I_CLK);
        err_count++;
        summarize();
    end
endmodule : testbench
